// File: rtl/tcp_timer2.sv
// Notes on behaviour
// RL1: Mode from run, trigger enable, capture select: off, ext-irq, reload, only, capture.
// RL2: Off state: counter does not advance.
// RL3: Counting modes run a 16-bit counter; wrap sets overflow flag.
// RL4: Capture mode: trigger falling edge copies count into reload/capture pair.
// RL5: Capture mode: trigger edge sets external event flag; overflow still flags.
// RL6: Auto-reload mode: overflow loads counter from reload/capture pair.
// RL7: Auto-reload with trigger enable: trigger edge flags and forces reload.
// RL8: Compare active whenever compare pair is nonzero, in any running mode.
// RL9: Counter incrementing to compare value sets the compare flag.
// RL10: Toggle enable routes toggle latch to port bit two.
// RL11: Toggle latch inverts on each compare match and each overflow.
// RL12: Toggle latch is low when toggle output is first enabled.
// RL13: Toggle, reload and compare together give PWM: reload period, compare duty.
// RL14: Zero compare with toggle: toggles only on overflow, 50% duty.
// RL15: Timer operation counts once per machine cycle of six oscillator periods.
// RL16: Counter operation counts detected falling edges of count input.
// RL17: Source holds each count input level at least one machine cycle.
// RL18: Alternative output reaches pin only while port latch bit is one.
// RL19: Flags stay set until software clears; software may also set them.
// RL20: Counter select: 0 internal one-sixth clock, 1 external falling edges.
// RL21: Clearing toggle enable resets the toggle latch.
// RL22: Trigger enable clear: trigger input ignored entirely.
// RL23: External-interrupt mode: counter stopped, trigger edge only sets event flag.
// RL24: Trigger and count inputs sampled per machine cycle; edge is high then low.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "tcp_consts.svh"

module tcp_timer2 (
	input  wire logic             sys_clk,       // 200 MHz clock
	input  wire logic             nrst,          // Async reset, active low
	input  wire logic [3:0]       reg_addr,      // Register address
	input  wire tcp_pkg::tcp_byte_t reg_wdata,   // Write data
	input  wire logic             reg_wr,        // Write strobe
	input  wire logic             reg_rd,        // Read strobe
	output tcp_pkg::tcp_byte_t    reg_rdata,     // Read data, cycle after strobe
	input  wire logic             count_input,   // External count pin
	input  wire logic             trigger_input, // External trigger pin
	output logic                  toggle_output_pin, // Port pin level
	output logic                  overflow_flag,       // Flag copies
	output logic                  external_event_flag, // Flag copy
	output logic                  compare_flag         // Flag copy
);
	import tcp_pkg::*;

	logic       [7:0] ctrl;
	logic       [7:0] port_latch;
	tcp_word_t        count;
	tcp_word_t        reload;
	tcp_word_t        cmp;
	logic             toggle_latch;
	logic       [2:0] mc_cnt;
	logic             mc_tick;
	logic       [1:0] cnt_sync;
	logic       [1:0] trg_sync;
	logic             cnt_samp;
	logic             trg_samp;
	logic             cnt_fall;
	logic             trg_fall;
	tcp_mode_t        mode;
	logic             run;
	logic             inc;
	logic             ovf;
	logic             cmp_hit;
	logic             trg_ev;
	logic             wr_ctrl;
	tcp_word_t        next_count;

	function automatic tcp_mode_t tcp_decode(input logic r, input logic t, input logic c);
		if (!r)
			return t ? TCP_EXT_IRQ : TCP_OFF;
		else if (!c)
			return TCP_RELOAD;
		else
			return t ? TCP_CAPTURE : TCP_ONLY;
	endfunction

	assign mode    = tcp_decode(ctrl[`TCP_BIT_RUN], ctrl[`TCP_BIT_TRIGEN],
		ctrl[`TCP_BIT_CAPSEL]);                           // see RL1
	assign run     = ctrl[`TCP_BIT_RUN];                  // see RL2
	assign wr_ctrl = reg_wr && (reg_addr == `TCP_ADDR_CONTROL);

	// Machine cycle divider
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			mc_cnt <= 3'h0;
		else if (mc_cnt == 3'(`TCP_MCYCLE_CLKS - 1))
			mc_cnt <= 3'h0;
		else
			mc_cnt <= mc_cnt + 3'h1;
	end
	assign mc_tick = (mc_cnt == 3'(`TCP_MCYCLE_CLKS - 1));   // see RL15

	// Pin synchronisers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_sync <= 2'h3;
			trg_sync <= 2'h3;
		end else begin
			cnt_sync <= {cnt_sync[0], count_input};
			trg_sync <= {trg_sync[0], trigger_input};
		end
	end

	// Once-per-machine-cycle sampling; edge is high sample then low
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_samp <= 1'b1;
			trg_samp <= 1'b1;
		end else if (mc_tick) begin
			cnt_samp <= cnt_sync[1];                          // see RL24
			trg_samp <= trg_sync[1];
		end
	end
	assign cnt_fall = mc_tick && cnt_samp && !cnt_sync[1];   // see RL16
	assign trg_fall = mc_tick && trg_samp && !trg_sync[1];   // see RL24
	assign trg_ev   = trg_fall && ctrl[`TCP_BIT_TRIGEN];     // see RL22

	assign inc     = run && (ctrl[`TCP_BIT_CNTSEL] ? cnt_fall : mc_tick); // see RL20
	assign ovf     = inc && (count == 16'hffff);                          // see RL3
	assign cmp_hit = inc && (cmp != 16'h0000) && (count + 16'h1 == cmp); // see RL8 RL9

	always_comb begin
		next_count = count;
		if (mode == TCP_RELOAD && (ovf || trg_ev))
			next_count = reload;                              // see RL6 RL7 RL13
		else if (inc)
			next_count = count + 16'h1;                       // see RL3
	end

	// Counter, with software writes taking priority
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			count <= 16'h0000;
		else if (reg_wr && reg_addr == `TCP_ADDR_COUNT_LO)
			count[7:0] <= reg_wdata;
		else if (reg_wr && reg_addr == `TCP_ADDR_COUNT_HI)
			count[15:8] <= reg_wdata;
		else
			count <= next_count;                              // see RL2 RL23
	end

	// Reload/capture pair; capture wins over a software write
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			reload <= 16'h0000;
		else if (mode == TCP_CAPTURE && trg_ev)
			reload <= count;                                  // see RL4
		else if (reg_wr && reg_addr == `TCP_ADDR_RELOAD_LO)
			reload[7:0] <= reg_wdata;
		else if (reg_wr && reg_addr == `TCP_ADDR_RELOAD_HI)
			reload[15:8] <= reg_wdata;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			cmp <= 16'h0000;
		else if (reg_wr && reg_addr == `TCP_ADDR_CMP_LO)
			cmp[7:0] <= reg_wdata;
		else if (reg_wr && reg_addr == `TCP_ADDR_CMP_HI)
			cmp[15:8] <= reg_wdata;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			port_latch <= `TCP_PORT_RESET;
		else if (reg_wr && reg_addr == `TCP_ADDR_PORT)
			port_latch <= reg_wdata;
	end

	// Control bits; hardware set wins over software clear
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= `TCP_CTRL_RESET;
		end else begin
			if (wr_ctrl)
				ctrl <= reg_wdata;                            // see RL19
			if (ovf)
				ctrl[`TCP_BIT_OVF] <= 1'b1;                   // see RL3 RL5
			if (trg_ev)
				ctrl[`TCP_BIT_EXTF] <= 1'b1;                  // see RL5 RL7 RL23
			if (cmp_hit)
				ctrl[`TCP_BIT_CMPF] <= 1'b1;                  // see RL9
		end
	end

	// Toggle latch, held low while disabled
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			toggle_latch <= 1'b0;
		else if (!ctrl[`TCP_BIT_TOGEN])
			toggle_latch <= 1'b0;                             // see RL12 RL21
		else if (ovf || cmp_hit)
			toggle_latch <= ~toggle_latch;                    // see RL11 RL14
	end

	// Pin: alternative function only while latch bit is one
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			toggle_output_pin <= 1'b1;
		else if (ctrl[`TCP_BIT_TOGEN])
			toggle_output_pin <= toggle_latch && port_latch[`TCP_BIT_PORT_TOG]; // see RL10 RL18
		else
			toggle_output_pin <= port_latch[`TCP_BIT_PORT_TOG];
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			overflow_flag       <= 1'b0;
			external_event_flag <= 1'b0;
			compare_flag        <= 1'b0;
		end else begin
			overflow_flag       <= ctrl[`TCP_BIT_OVF];
			external_event_flag <= ctrl[`TCP_BIT_EXTF];
			compare_flag        <= ctrl[`TCP_BIT_CMPF];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`TCP_ADDR_CONTROL:   reg_rdata <= ctrl;
				`TCP_ADDR_COUNT_LO:  reg_rdata <= count[7:0];
				`TCP_ADDR_COUNT_HI:  reg_rdata <= count[15:8];
				`TCP_ADDR_RELOAD_LO: reg_rdata <= reload[7:0];
				`TCP_ADDR_RELOAD_HI: reg_rdata <= reload[15:8];
				`TCP_ADDR_CMP_LO:    reg_rdata <= cmp[7:0];
				`TCP_ADDR_CMP_HI:    reg_rdata <= cmp[15:8];
				`TCP_ADDR_PORT:      reg_rdata <= port_latch;
				default:             reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	a_off_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
		(mode == TCP_OFF || mode == TCP_EXT_IRQ) && !reg_wr |=> $stable(count))  // see RL2
		else $error("Counter moved while stopped");
	a_ovf_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
		ovf |=> ctrl[`TCP_BIT_OVF])  // see RL3
		else $error("Overflow flag not set");
	a_capture_copy: assert property (@(posedge sys_clk) disable iff (!nrst)
		mode == TCP_CAPTURE && trg_ev |=> reload == $past(count))  // see RL4
		else $error("Capture did not copy count");
	a_reload_load: assert property (@(posedge sys_clk) disable iff (!nrst)
		mode == TCP_RELOAD && ovf && !reg_wr |=> count == $past(reload))  // see RL6
		else $error("Reload not taken");
	a_trig_ignored: assert property (@(posedge sys_clk) disable iff (!nrst)
		!ctrl[`TCP_BIT_TRIGEN] && !wr_ctrl && !ctrl[`TCP_BIT_EXTF]
		|=> !ctrl[`TCP_BIT_EXTF])  // see RL22
		else $error("Event flag set with trigger disabled");
	a_cmp_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
		inc && cmp != 16'h0000 && count + 16'h1 == cmp |=> ctrl[`TCP_BIT_CMPF])  // see RL9
		else $error("Compare flag not set");
	a_toggle_flip: assert property (@(posedge sys_clk) disable iff (!nrst)
		ctrl[`TCP_BIT_TOGEN] && !wr_ctrl && (ovf || cmp_hit)
		|=> toggle_latch != $past(toggle_latch))  // see RL11
		else $error("Toggle latch did not invert");
	a_toggle_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
		!ctrl[`TCP_BIT_TOGEN] |=> !toggle_latch)  // see RL21
		else $error("Toggle latch not reset");
	a_pin_gated: assert property (@(posedge sys_clk) disable iff (!nrst)
		!port_latch[`TCP_BIT_PORT_TOG] |=> !toggle_output_pin)  // see RL18
		else $error("Pin high with latch bit zero");
	a_mc_rate: assert property (@(posedge sys_clk) disable iff (!nrst)
		mc_tick |=> !mc_tick [*5] ##1 mc_tick)  // see RL15
		else $error("Machine cycle not six clocks");

	// Mode decode against the control bits
	a_mode_off: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL1
		!ctrl[`TCP_BIT_RUN] && !ctrl[`TCP_BIT_TRIGEN] |-> mode == TCP_OFF)
		else $error("Off mode not decoded");

	a_mode_reload: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL1
		ctrl[`TCP_BIT_RUN] && !ctrl[`TCP_BIT_CAPSEL] |-> mode == TCP_RELOAD)
		else $error("Reload mode not decoded");

	a_ext_flag_set: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL5
		trg_ev |=> ctrl[`TCP_BIT_EXTF])
		else $error("Event flag not set");

	// Flags hold until software clears them
	a_ovf_hold: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL19
		ctrl[`TCP_BIT_OVF] && !wr_ctrl |=> ctrl[`TCP_BIT_OVF])
		else $error("Overflow flag dropped");

	a_ext_hold: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL19
		ctrl[`TCP_BIT_EXTF] && !wr_ctrl |=> ctrl[`TCP_BIT_EXTF])
		else $error("Event flag dropped");

	a_cmp_hold: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL19
		ctrl[`TCP_BIT_CMPF] && !wr_ctrl |=> ctrl[`TCP_BIT_CMPF])
		else $error("Compare flag dropped");

	a_sw_set: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL19
		wr_ctrl && reg_wdata[`TCP_BIT_OVF] |=> ctrl[`TCP_BIT_OVF])
		else $error("Software set of flag lost");

	// Counter paths
	a_wrap_zero: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL3
		ovf && mode != TCP_RELOAD && !reg_wr |=> count == 16'h0000)
		else $error("Counter did not wrap to zero");

	a_trig_reload: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL7
		mode == TCP_RELOAD && trg_ev && !reg_wr |=> count == $past(reload))
		else $error("Trigger reload not taken");

	a_extirq_stop: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL23
		mode == TCP_EXT_IRQ && !reg_wr |=> $stable(reload))
		else $error("Capture in external interrupt mode");

	a_no_capture: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL22
		!ctrl[`TCP_BIT_TRIGEN] && !reg_wr |=> $stable(reload))
		else $error("Capture with trigger disabled");

	a_timer_inc: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL15
		run && !ctrl[`TCP_BIT_CNTSEL] && mc_tick && !reg_wr && !trg_ev
		&& count != 16'hffff |=> count == $past(count) + 16'h1)
		else $error("Timer did not step");

	a_count_idle: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL16
		run && ctrl[`TCP_BIT_CNTSEL] && !cnt_fall && !reg_wr && !trg_ev
		|=> $stable(count))
		else $error("Counter moved without edge");

	// Pin and flag outputs
	a_pin_follow: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL10
		ctrl[`TCP_BIT_TOGEN]
		|=> toggle_output_pin == ($past(toggle_latch) && $past(port_latch[`TCP_BIT_PORT_TOG])))
		else $error("Pin not driven by toggle latch");

	a_toggle_start: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL12
		$rose(ctrl[`TCP_BIT_TOGEN]) |-> !toggle_latch)
		else $error("Toggle latch high at enable");

	a_flag_copy: assert property (@(posedge sys_clk) disable iff (!nrst)  // see RL3
		ctrl[`TCP_BIT_OVF] |=> overflow_flag)
		else $error("Overflow output not following");
endmodule

// File: rtl/tcp_consts.svh
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH

// Register addresses (byte-wide registers on the plain port)
`define TCP_ADDR_CONTROL   4'h0
`define TCP_ADDR_COUNT_LO  4'h1
`define TCP_ADDR_COUNT_HI  4'h2
`define TCP_ADDR_RELOAD_LO 4'h3
`define TCP_ADDR_RELOAD_HI 4'h4
`define TCP_ADDR_CMP_LO    4'h5
`define TCP_ADDR_CMP_HI    4'h6
`define TCP_ADDR_PORT      4'h7

// Control register bit positions
`define TCP_BIT_CAPSEL     0
`define TCP_BIT_CNTSEL     1
`define TCP_BIT_RUN        2
`define TCP_BIT_TRIGEN     3
`define TCP_BIT_TOGEN      4
`define TCP_BIT_CMPF       5
`define TCP_BIT_EXTF       6
`define TCP_BIT_OVF        7

// Port latch bit that carries the toggle output
`define TCP_BIT_PORT_TOG   2

`define TCP_CTRL_RESET     8'h00
`define TCP_PORT_RESET     8'hff

// Machine cycle: oscillator periods, with one sys_clk per oscillator period
`define TCP_OSC_PER_MCYCLE 6
`define TCP_OSC_NS         5
`define TCP_MCYCLE_CLKS    ((`TCP_OSC_PER_MCYCLE * `TCP_OSC_NS + `TCP_OSC_NS - 1) / `TCP_OSC_NS)

`endif

// File: rtl/tcp_pkg.sv
package tcp_pkg;
	typedef enum logic [2:0] {
		TCP_OFF       = 3'b000,
		TCP_EXT_IRQ   = 3'b001,
		TCP_RELOAD    = 3'b010,
		TCP_ONLY      = 3'b011,
		TCP_CAPTURE   = 3'b100
	} tcp_mode_t;
	typedef logic [7:0]  tcp_byte_t;
	typedef logic [15:0] tcp_word_t;
endpackage

// File: verification/tcp_pin_src.sv
`timescale 1ns/1ps
module tcp_pin_src (
	input  wire logic sys_clk,       // Bench clock
	output logic      count_input,   // Count pin, idles high
	output logic      trigger_input  // Trigger pin, idles high
);
	initial begin
		count_input = 1'b1;
		trigger_input = 1'b1;
	end

	// Falling edges; each level held 8 clocks so every sample sees it
	task automatic fall(input bit trig, input int n);
		repeat (n) begin
			if (trig) begin
				trigger_input <= 1'b0;
			end else begin
				count_input <= 1'b0;
			end
			repeat (8) @(posedge sys_clk);
			trigger_input <= 1'b1;
			count_input <= 1'b1;
			repeat (8) @(posedge sys_clk);
		end
	endtask
endmodule

// File: verification/test_timer2_capture_compare_pwm.sv
`timescale 1ns/1ps
`include "tcp_consts.svh"
`define TB_CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_timer2_capture_compare_pwm;
	import tcp_pkg::*;
	logic       sys_clk;
	logic       nrst;
	logic [3:0] reg_addr;
	tcp_byte_t  reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	tcp_byte_t  reg_rdata;
	logic       count_input;
	logic       trigger_input;
	logic       toggle_output_pin;
	logic       overflow_flag;
	logic       external_event_flag;
	logic       compare_flag;
	int         failures;
	int         cmp_count;
	tcp_byte_t  q;
	tcp_word_t  r;

	tcp_timer2 DUT (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.count_input(count_input), .trigger_input(trigger_input),
		.toggle_output_pin(toggle_output_pin), .overflow_flag(overflow_flag),
		.external_event_flag(external_event_flag), .compare_flag(compare_flag));
	tcp_pin_src u_src (.sys_clk(sys_clk), .count_input(count_input),
		.trigger_input(trigger_input));

	function automatic tcp_byte_t ctl(bit tog, bit trig, bit run, bit cnt, bit cap);
		return {3'h0, tog, trig, run, cnt, cap};
	endfunction

	task automatic bus(input bit w, input logic [3:0] a, input tcp_byte_t d,
		output tcp_byte_t rq);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		rq = reg_rdata;
		@(posedge sys_clk);
	endtask
	task automatic pin_chk(input logic e);
		@(negedge sys_clk);
		`TB_CHK("pin", e, toggle_output_pin)
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [3:0] a, input tcp_byte_t d);
		tcp_byte_t rq;
		bus(1'b1, a, d, rq);
	endtask
	task automatic rck(input logic [3:0] a, input tcp_byte_t e);
		tcp_byte_t rq;
		bus(1'b0, a, 8'h00, rq);
		`TB_CHK("register", e, rq)
	endtask
	task automatic test_done;
		if (failures == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		test_done();
	end

	initial begin
		failures = 0;
		cmp_count = 0;
		nrst = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		r = $urandom(59);
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		rck(`TCP_ADDR_CONTROL, 8'h00);
		rck(`TCP_ADDR_PORT, 8'hff);
		rck(4'h9, 8'h00);
		// Off: counter frozen, then timer rate of one per six clocks
		wr(`TCP_ADDR_COUNT_LO, 8'h10);
		repeat (30) @(posedge sys_clk);
		rck(`TCP_ADDR_COUNT_LO, 8'h10);
		wr(`TCP_ADDR_CONTROL, ctl(0, 0, 1, 0, 1));
		repeat (58) @(posedge sys_clk);
		wr(`TCP_ADDR_CONTROL, 8'h00);
		bus(1'b0, `TCP_ADDR_COUNT_LO, 8'h00, q);
		`TB_CHK("rate", 1'b1, q >= 8'h19 && q <= 8'h1b)
		wr(`TCP_ADDR_COUNT_HI, 8'hff);
		wr(`TCP_ADDR_COUNT_LO, 8'hfd);
		wr(`TCP_ADDR_CONTROL, ctl(0, 0, 1, 0, 1));
		for (int n = 0; n < 40 && overflow_flag !== 1'b1; n++) @(posedge sys_clk);
		@(negedge sys_clk);
		`TB_CHK("overflow", 1'b1, overflow_flag)
		@(posedge sys_clk);
		wr(`TCP_ADDR_CONTROL, 8'h81);
		rck(`TCP_ADDR_CONTROL, 8'h81);
		rck(`TCP_ADDR_COUNT_HI, 8'h00);
		// Capture of random counts, counter mode with no count edges
		for (int n = 0; n < 4; n++) begin
			r = tcp_word_t'($urandom);
			wr(`TCP_ADDR_CONTROL, 8'h00);
			wr(`TCP_ADDR_COUNT_LO, r[7:0]);
			wr(`TCP_ADDR_COUNT_HI, r[15:8]);
			wr(`TCP_ADDR_CONTROL, ctl(0, 1, 1, 1, 1));
			u_src.fall(1'b1, 1);
			rck(`TCP_ADDR_CONTROL, ctl(0, 1, 1, 1, 1) | 8'h40);
			rck(`TCP_ADDR_RELOAD_LO, r[7:0]);
			rck(`TCP_ADDR_RELOAD_HI, r[15:8]);
		end
		wr(`TCP_ADDR_CONTROL, ctl(0, 0, 1, 1, 1));
		wr(`TCP_ADDR_COUNT_LO, ~r[7:0]);
		u_src.fall(1'b1, 1);
		rck(`TCP_ADDR_CONTROL, ctl(0, 0, 1, 1, 1));
		rck(`TCP_ADDR_RELOAD_LO, r[7:0]);
		wr(`TCP_ADDR_CONTROL, ctl(0, 1, 0, 0, 0));
		u_src.fall(1'b1, 1);
		rck(`TCP_ADDR_CONTROL, ctl(0, 1, 0, 0, 0) | 8'h40);
		rck(`TCP_ADDR_RELOAD_LO, r[7:0]);
		rck(`TCP_ADDR_COUNT_LO, ~r[7:0]);
		// Auto-reload by trigger, by overflow, then external counting
		wr(`TCP_ADDR_RELOAD_LO, 8'h34);
		wr(`TCP_ADDR_RELOAD_HI, 8'h12);
		wr(`TCP_ADDR_CONTROL, ctl(0, 1, 1, 1, 0));
		u_src.fall(1'b1, 1);
		rck(`TCP_ADDR_CONTROL, 8'h4e);
		rck(`TCP_ADDR_COUNT_HI, 8'h12);
		wr(`TCP_ADDR_CONTROL, ctl(0, 0, 1, 1, 0));
		wr(`TCP_ADDR_COUNT_LO, 8'hff);
		wr(`TCP_ADDR_COUNT_HI, 8'hff);
		u_src.fall(1'b0, 1);
		rck(`TCP_ADDR_CONTROL, 8'h86);
		rck(`TCP_ADDR_COUNT_LO, 8'h34);
		u_src.fall(1'b0, 3);
		rck(`TCP_ADDR_COUNT_LO, 8'h37);
		// Toggle output: overflow and compare, pin gating by port latch
		wr(`TCP_ADDR_CONTROL, ctl(1, 0, 0, 1, 0));
		pin_chk(1'b0);
		wr(`TCP_ADDR_COUNT_LO, 8'hff);
		wr(`TCP_ADDR_COUNT_HI, 8'hff);
		wr(`TCP_ADDR_CONTROL, ctl(1, 0, 1, 1, 0));
		u_src.fall(1'b0, 1);
		pin_chk(1'b1);
		wr(`TCP_ADDR_CMP_LO, 8'h38);
		wr(`TCP_ADDR_CMP_HI, 8'h12);
		u_src.fall(1'b0, 4);
		rck(`TCP_ADDR_CONTROL, 8'hb6);
		pin_chk(1'b0);
		wr(`TCP_ADDR_COUNT_LO, 8'hff);
		wr(`TCP_ADDR_COUNT_HI, 8'hff);
		u_src.fall(1'b0, 1);
		pin_chk(1'b1);
		wr(`TCP_ADDR_PORT, 8'hfb);
		pin_chk(1'b0);
		wr(`TCP_ADDR_PORT, 8'hff);
		wr(`TCP_ADDR_CONTROL, ctl(0, 0, 0, 1, 0));
		pin_chk(1'b1);
		wr(`TCP_ADDR_CONTROL, ctl(1, 0, 0, 1, 0));
		pin_chk(1'b0);
		wr(`TCP_ADDR_CONTROL, 8'he0);
		rck(`TCP_ADDR_CONTROL, 8'he0);
		@(negedge sys_clk);
		`TB_CHK("flags", 3'h7, {overflow_flag, external_event_flag, compare_flag})
		test_done();
	end
endmodule
